// ===== rtl/vsl_driver.sv
// Serial shift register, output latch and blanking of the display driver front end
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [R1] Serial input enters the first shift stage on each rising serial clock edge.
// [R2] Every rising serial clock edge shifts; cascade output shows the last stage.
// [R3] Blanking high forces all twenty outputs low; latch contents stay untouched.
// [R4] Blanking low lets each output show its latch bit.
// [R5] Load high makes the latch transparent to the shift register contents.
// [R6] Load low holds the latch whatever the serial inputs do.
// [R7] Latch captures shift contents present when load falls from high to low.
// [R8] Controller sends twenty bits, first shifted bit first, before closing the latch.
// [R9] Reset clears shift register and latch; outputs and cascade output start low.
// [R10] A bit reaches the cascade output twenty serial clocks after entering.
// [R11] Blanking does not disturb shifting or latching.
module vsl_driver #(
  parameter int DRV_BITS = vsl_pkg::DRV_WIDTH,
  parameter int FIFO_WORDS = vsl_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic ser_din,
  input wire logic ser_load,
  input wire logic ser_blank,
  input wire logic drain_hold,
  output logic [DRV_BITS-1:0] driver_outputs,
  output logic ser_dout,
  output logic link_ready,
  output logic link_overrun
);
  import vsl_pkg::*;

  localparam int LAST_STAGE = DRV_BITS - 1;

  if (DRV_BITS != DRV_WIDTH) begin : g_bits_chk
    $error("vsl_driver supports only the documented output count");
  end
  if (FIFO_WORDS < 4) begin : g_words_chk
    $error("vsl_driver needs a buffer of at least four words");
  end
  if (CATCH_CYCLES >= (1 << CATCH_CNT_W)) begin : g_catch_chk
    $error("vsl_driver catch window does not fit its counter");
  end
  if (CATCH_CYCLES < 1) begin : g_catch_min_chk
    $error("vsl_driver catch window must last at least one cycle");
  end
  if (CATCH_CNT_W < 1) begin : g_catch_w_chk
    $error("vsl_driver catch counter needs at least one bit");
  end
  if (DRV_BITS < 2) begin : g_stages_chk
    $error("vsl_driver shift register needs at least two stages");
  end

  // Power-up must leave every driver and the cascade output low
  if (SHIFT_RESET != '0) begin : g_shift_rst_chk
    $error("vsl_driver shift register must power up cleared");
  end
  if (LATCH_RESET != '0) begin : g_latch_rst_chk
    $error("vsl_driver latch must power up cleared");
  end
  if (DRV_BLANKED != '0) begin : g_blank_lvl_chk
    $error("vsl_driver blanked outputs must be low");
  end

  // A synchronised pin changes only once the second and third stages agree
  function automatic logic settle(input logic cur, input logic s2, input logic s3);
    settle = (s2 == s3) ? s3 : cur;
  endfunction

  // ------------------------------------------------------------------
  // Serial clock domain: shift register and cascade output
  // ------------------------------------------------------------------

  logic [DRV_BITS-1:0] shift_r;
  logic [DRV_BITS-1:0] shift_nxt;
  logic overrun_r;
  logic overrun_nxt;
  logic fifo_wr_ready;

  // Data input is launched by the controller around the serial clock, so it is
  // sampled here directly and needs no synchroniser
  always_comb begin
    shift_nxt = {shift_r[DRV_BITS-2:0], ser_din}; // [R1] [R2] [R8]
    overrun_nxt = overrun_r | ~fifo_wr_ready;
  end

  // Reset acts without the serial clock so the cascade output is low even
  // while the controller keeps the clock still
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= SHIFT_RESET; // [R9]
      overrun_r <= FLAG_RESET;
    end else begin
      shift_r <= shift_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  // The last stage itself is the cascade output, a full word length behind the input
  assign ser_dout = shift_r[LAST_STAGE]; // [R2] [R10]
  assign link_overrun = overrun_r;
  assign link_ready = fifo_wr_ready;

  // ------------------------------------------------------------------
  // Crossing: each new shift register state goes to the system clock while the buffer has room
  // ------------------------------------------------------------------

  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [DRV_BITS-1:0] fifo_rd_data;

  // Shift activity never waits on the latch side; a full buffer shows as overrun
  vsl_fifo #(
    .WIDTH(DRV_BITS),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .clk_wr(link_clk),
    .clk_rd(clk_sys),
    .rst_n(rst_n),
    .wr_valid(1'h1),
    .wr_ready(fifo_wr_ready),
    .wr_data(shift_nxt),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(fifo_rd_data)
  );

  // ------------------------------------------------------------------
  // System clock domain: reset release
  // ------------------------------------------------------------------

  // Reset asserts at once everywhere, but its release passes three stages so
  // that every system clock flip-flop leaves reset on the same edge.
  // The buffer keeps the raw reset: its write side must be live as soon as
  // the serial clock may run, which a local release could not promise.
  logic [2:0] rst_sync_r;
  logic [2:0] rst_sync_nxt;
  logic sys_rst_n;

  always_comb begin
    rst_sync_nxt = {rst_sync_r[1:0], 1'h1};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= '0;
    end else begin
      rst_sync_r <= rst_sync_nxt;
    end
  end

  // Release counts once the second and third stages agree
  assign sys_rst_n = rst_sync_r[2] & rst_sync_r[1];

  // ------------------------------------------------------------------
  // System clock domain: control pin synchronisers
  // ------------------------------------------------------------------

  vsl_ctrl_type pins;
  vsl_ctrl_type ctrl_s1_r;
  vsl_ctrl_type ctrl_s2_r;
  vsl_ctrl_type ctrl_s3_r;
  vsl_ctrl_type ctrl_r;
  vsl_ctrl_type ctrl_nxt;

  always_comb begin
    pins.load = ser_load;
    pins.blank = ser_blank;
    ctrl_nxt.load = settle(ctrl_r.load, ctrl_s2_r.load, ctrl_s3_r.load);
    ctrl_nxt.blank = settle(ctrl_r.blank, ctrl_s2_r.blank, ctrl_s3_r.blank);
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ctrl_s1_r <= CTRL_IDLE;
      ctrl_s2_r <= CTRL_IDLE;
      ctrl_s3_r <= CTRL_IDLE;
      ctrl_r <= CTRL_IDLE;
    end else begin
      ctrl_s1_r <= pins;
      ctrl_s2_r <= ctrl_s1_r;
      ctrl_s3_r <= ctrl_s2_r;
      ctrl_r <= ctrl_nxt;
    end
  end

  // ------------------------------------------------------------------
  // System clock domain: mirror of the shift register
  // ------------------------------------------------------------------

  logic [DRV_BITS-1:0] mirror_r;
  logic [DRV_BITS-1:0] mirror_nxt;
  logic pop;

  // Holding the drain lets the buffer fill; the mirror then lags the shift register.
  // Nothing is taken while the mirror is still held in reset, or the word would be lost.
  assign fifo_rd_ready = ~drain_hold & sys_rst_n;

  always_comb begin
    pop = fifo_rd_valid & fifo_rd_ready;
    mirror_nxt = pop ? fifo_rd_data : mirror_r;
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      mirror_r <= SHIFT_RESET; // [R9]
    end else begin
      mirror_r <= mirror_nxt;
    end
  end

  // ------------------------------------------------------------------
  // System clock domain: output latch
  // ------------------------------------------------------------------

  vsl_latch_state_type state_r;
  vsl_latch_state_type state_nxt;
  logic [CATCH_CNT_W-1:0] catch_cnt_r;
  logic [CATCH_CNT_W-1:0] catch_cnt_nxt;
  logic [DRV_BITS-1:0] latch_r;
  logic [DRV_BITS-1:0] latch_nxt;

  // Blanking is not an input of this process, so it cannot disturb latching
  always_comb begin
    state_nxt = state_r;
    catch_cnt_nxt = catch_cnt_r;
    latch_nxt = latch_r;
    // Follow tracks the mirror while load is high, catch keeps tracking for the
    // crossing delay after load falls, hold freezes the word until load returns
    unique case (state_r)
      LATCH_FOLLOW: begin
        latch_nxt = mirror_nxt; // [R5] [R11]
        if (!ctrl_r.load) begin
          state_nxt = LATCH_CATCH;
          catch_cnt_nxt = CATCH_CNT_W'(CATCH_CYCLES - 1);
        end
      end
      LATCH_CATCH: begin
        // Shifts already on their way when load fell still belong to the word
        latch_nxt = mirror_nxt; // [R7]
        if (ctrl_r.load) begin
          state_nxt = LATCH_FOLLOW;
        end else if (catch_cnt_r == '0) begin
          state_nxt = LATCH_HOLD;
        end else begin
          catch_cnt_nxt = catch_cnt_r - 1'b1;
        end
      end
      LATCH_HOLD: begin
        latch_nxt = latch_r; // [R6]
        if (ctrl_r.load) begin
          state_nxt = LATCH_FOLLOW;
        end
      end
      default: begin
        state_nxt = LATCH_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state_r <= LATCH_HOLD;
      catch_cnt_r <= '0;
      latch_r <= LATCH_RESET; // [R9]
    end else begin
      state_r <= state_nxt;
      catch_cnt_r <= catch_cnt_nxt;
      latch_r <= latch_nxt;
    end
  end

  // ------------------------------------------------------------------
  // System clock domain: blanking and driver outputs
  // ------------------------------------------------------------------

  logic [DRV_BITS-1:0] drv_r;
  logic [DRV_BITS-1:0] drv_nxt;

  // Blanking only gates the outputs; the latch keeps its word underneath.
  // Registered so that a change of blanking cannot glitch a driver.
  always_comb begin
    if (ctrl_r.blank) begin
      drv_nxt = DRV_BLANKED; // [R3]
    end else begin
      drv_nxt = latch_r; // [R4]
    end
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      drv_r <= DRV_BLANKED; // [R9]
    end else begin
      drv_r <= drv_nxt;
    end
  end

  assign driver_outputs = drv_r;

endmodule
`default_nettype wire

// ===== rtl/vsl_fifo.sv
// Dual-clock FIFO with gray-coded pointers between the serial clock and the system clock
`timescale 1ns/1ns
`default_nettype none
module vsl_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input wire logic clk_wr,
  input wire logic clk_rd,
  input wire logic rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("vsl_fifo depth must be a power of two, at least 4");
  end
  if (WIDTH < 1) begin : g_width_chk
    $error("vsl_fifo width must be at least 1");
  end

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];

  logic [PW-1:0] wbin_r, wbin_nxt, wgray_r, wgray_nxt;
  logic [PW-1:0] rbin_r, rbin_nxt, rgray_r, rgray_nxt;
  logic [PW-1:0] rg_w1_r, rg_w2_r;
  logic [PW-1:0] wg_r1_r, wg_r2_r;
  logic push, pop, full, empty;

  // Full compares against the read pointer as seen in the write domain; it may
  // keep reporting full after a read until serial clock edges carry the read pointer over, which is harmless
  always_comb begin
    full = (wgray_r == {~rg_w2_r[PW-1:PW-2], rg_w2_r[PW-3:0]});
    push = wr_valid & ~full;
    wbin_nxt = push ? wbin_r + 1'b1 : wbin_r;
    wgray_nxt = to_gray(wbin_nxt);
  end

  always_comb begin
    empty = (rgray_r == wg_r2_r);
    pop = rd_ready & ~empty;
    rbin_nxt = pop ? rbin_r + 1'b1 : rbin_r;
    rgray_nxt = to_gray(rbin_nxt);
  end

  assign wr_ready = ~full;
  assign rd_valid = ~empty;
  assign rd_data = mem[rbin_r[AW-1:0]];

  always_ff @(posedge clk_wr) begin
    if (push) begin
      mem[wbin_r[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk_wr or negedge rst_n) begin
    if (!rst_n) begin
      wbin_r <= '0;
      wgray_r <= '0;
      rg_w1_r <= '0;
      rg_w2_r <= '0;
    end else begin
      wbin_r <= wbin_nxt;
      wgray_r <= wgray_nxt;
      rg_w1_r <= rgray_r;
      rg_w2_r <= rg_w1_r;
    end
  end

  always_ff @(posedge clk_rd or negedge rst_n) begin
    if (!rst_n) begin
      rbin_r <= '0;
      rgray_r <= '0;
      wg_r1_r <= '0;
      wg_r2_r <= '0;
    end else begin
      rbin_r <= rbin_nxt;
      rgray_r <= rgray_nxt;
      wg_r1_r <= wgray_r;
      wg_r2_r <= wg_r1_r;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/vsl_pkg.sv
// Shared constants, carrier types and state codes of the display driver serial front end
package vsl_pkg;

  // Number of driver outputs and shift stages
  localparam int DRV_WIDTH = 20;

  // Words buffered between the serial clock and the system clock
  localparam int FIFO_DEPTH = 8;

  // System clock rate
  localparam int SYS_CLK_MHZ = 100;

  // Time the latch keeps following after the load input is seen low, so that
  // shifts already in flight through the crossing still reach the latch
  localparam int CATCH_NS = 50;
  localparam int CATCH_RAW = (CATCH_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int CATCH_CYCLES = (CATCH_RAW < 1) ? 1 : CATCH_RAW;
  localparam int CATCH_CNT_W = 4;

  // Power-up contents of the shift register, the latch and the outputs
  localparam logic [DRV_WIDTH-1:0] SHIFT_RESET = 20'h00000;
  localparam logic [DRV_WIDTH-1:0] LATCH_RESET = 20'h00000;
  localparam logic [DRV_WIDTH-1:0] DRV_BLANKED = 20'h00000;

  // Level of a control pin after reset
  localparam logic CTRL_RESET = 1'h0;

  // Overrun flag after reset
  localparam logic FLAG_RESET = 1'h0;

  // Control pins that travel together through the synchroniser
  typedef struct packed {
    logic load;
    logic blank;
  } vsl_ctrl_type;

  localparam vsl_ctrl_type CTRL_IDLE = '{load: CTRL_RESET, blank: CTRL_RESET};

  // Output latch behaviour
  typedef enum logic [1:0] {
    LATCH_FOLLOW = 2'b00,
    LATCH_CATCH  = 2'b01,
    LATCH_HOLD   = 2'b10
  } vsl_latch_state_type;

endpackage

// ===== testbench/vsl_ctl_model.sv
// Controller model driving the serial clock and data line
`timescale 1ns/1ns
`default_nettype none
module vsl_ctl_model (
  output logic link_clk,
  output logic ser_din
);
  initial begin
    link_clk = 1'b0;
    ser_din = 1'b0;
  end
  // Clock stands still low between frames; 64 ns per bit
  task automatic send_bits(input logic [19:0] w, input int n);
    #3;
    for (int i = 19; i > 19 - n; i--) begin
      ser_din = w[i];
      #32 link_clk = 1'b1;
      #32 link_clk = 1'b0;
    end
    // Released line must not keep showing the last bit
    ser_din = ~ser_din;
  endtask
endmodule
`default_nettype wire

// ===== testbench/vsl_driver_chk.sv
// Concurrent checks on the display driver serial front end ports
`timescale 1ns/1ns
`default_nettype none
module vsl_driver_chk #(
  parameter int DRV_BITS = 20,
  parameter int FIFO_WORDS = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic ser_din,
  input wire logic ser_load,
  input wire logic ser_blank,
  input wire logic drain_hold,
  input wire logic [DRV_BITS-1:0] driver_outputs,
  input wire logic ser_dout,
  input wire logic link_ready,
  input wire logic link_overrun
);
  logic [4:0] lk_cnt_r;
  logic [4:0] lk_cnt_nxt;
  logic quiet;
  // Link edges since reset, saturating, so history checks skip the unfilled chain
  always_comb begin
    lk_cnt_nxt = (lk_cnt_r == 5'h1F) ? lk_cnt_r : lk_cnt_r + 5'h01;
  end
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_cnt_r <= 5'h00;
    end else begin
      lk_cnt_r <= lk_cnt_nxt;
    end
  end
  assign quiet = !ser_load && !ser_blank && !drain_hold;
  chk_dout_early: assert property (@(posedge link_clk) disable iff (!rst_n)
    lk_cnt_r < 5'h14 |-> !ser_dout) else $error("cascade output high before twenty shifts");
  chk_dout_delay: assert property (@(posedge link_clk) disable iff (!rst_n)
    lk_cnt_r >= 5'h14 |-> ser_dout == $past(ser_din, 20)) else $error("cascade output delay wrong");
  chk_reset_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> driver_outputs == '0 && !ser_dout && !link_overrun && link_ready)
    else $error("state not cleared by reset");
  chk_blank_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ser_blank[*8] |-> driver_outputs == '0) else $error("outputs not low while blanked");
  chk_hold_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    quiet[*8] ##1 quiet[*8] |=> $stable(driver_outputs)) else $error("outputs moved with latch closed");
  chk_overrun_set: assert property (@(posedge link_clk) disable iff (!rst_n)
    !link_ready |=> link_overrun) else $error("overrun not flagged on full buffer");
  chk_overrun_keep: assert property (@(posedge link_clk) disable iff (!rst_n)
    link_overrun |=> link_overrun) else $error("overrun flag cleared");
  chk_overrun_cause: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(link_overrun) |-> !$past(link_ready)) else $error("overrun without full buffer");
  cov_blank: cover property (@(posedge clk_sys) disable iff (!rst_n) ser_blank[*8]);
  cov_chain: cover property (@(posedge link_clk) disable iff (!rst_n) lk_cnt_r == 5'h1F);
  cov_overrun: cover property (@(posedge link_clk) disable iff (!rst_n) $rose(link_overrun));
endmodule
bind vsl_driver vsl_driver_chk #(.DRV_BITS(DRV_BITS), .FIFO_WORDS(FIFO_WORDS)) u_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .link_clk(link_clk), .ser_din(ser_din), .ser_load(ser_load), .ser_blank(ser_blank),
  .drain_hold(drain_hold), .driver_outputs(driver_outputs), .ser_dout(ser_dout), .link_ready(link_ready),
  .link_overrun(link_overrun));
`default_nettype wire

// ===== testbench/vsl_driver_tb_top.sv
// Self-checking bench of the display driver serial front end
`timescale 1ns/1ns
`default_nettype none
module vsl_driver_tb_top;
  import vsl_pkg::*;
  logic clk_sys, rst_n, ser_load, ser_blank, drain_hold;
  logic link_clk, ser_din, ser_dout, link_ready, link_overrun;
  logic [DRV_WIDTH-1:0] driver_outputs;
  int num_errors, cmp_count, cyc;
  vsl_ctl_model u_ctl (.link_clk(link_clk), .ser_din(ser_din));
  vsl_driver #(.DRV_BITS(DRV_WIDTH), .FIFO_WORDS(FIFO_DEPTH)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .link_clk(link_clk), .ser_din(ser_din), .ser_load(ser_load), .ser_blank(ser_blank),
    .drain_hold(drain_hold), .driver_outputs(driver_outputs), .ser_dout(ser_dout),
    .link_ready(link_ready), .link_overrun(link_overrun));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Load held long after the last shift so late words still reach the latch
  task automatic pulse_load();
    wait_clk(1);
    ser_load = 1'b1;
    wait_clk(20);
    ser_load = 1'b0;
    wait_clk(30);
  endtask
  task automatic t_reset();
    check("outputs", 20'h00000, driver_outputs);
    check("cascade", 20'h00000, {19'h0, ser_dout});
  endtask
  task automatic t_load();
    ser_load = 1'b1;
    u_ctl.send_bits(20'hA5C3F, 20);
    wait_clk(20);
    check("transparent", 20'hA5C3F, driver_outputs);
    check("cascade", 20'h00001, {19'h0, ser_dout});
    ser_load = 1'b0;
    wait_clk(30);
    check("latched", 20'hA5C3F, driver_outputs);
  endtask
  task automatic t_hold();
    u_ctl.send_bits(20'h5A3C0, 20);
    wait_clk(20);
    check("held", 20'hA5C3F, driver_outputs);
    check("cascade", {19'h0, 1'b0}, {19'h0, ser_dout});
    pulse_load();
    check("reloaded", 20'h5A3C0, driver_outputs);
  endtask
  task automatic t_blank();
    ser_blank = 1'b1;
    wait_clk(10);
    check("blanked", 20'h00000, driver_outputs);
    u_ctl.send_bits(20'hF0F0F, 20);
    pulse_load();
    check("blanked", 20'h00000, driver_outputs);
    ser_blank = 1'b0;
    wait_clk(10);
    check("unblanked", 20'hF0F0F, driver_outputs);
  endtask
  // Drain stalled while the link keeps shifting: buffer must refuse and flag it
  task automatic t_overrun();
    drain_hold = 1'b1;
    wait_clk(5);
    u_ctl.send_bits(20'hFFFFF, 12);
    check("ready", 20'h00000, {19'h0, link_ready});
    check("overrun", 20'h00001, {19'h0, link_overrun});
    wait_clk(1);
    drain_hold = 1'b0;
    wait_clk(40);
    // The write side sees the drained buffer only through serial clock edges
    u_ctl.send_bits(20'h00000, 3);
    wait_clk(1);
    check("ready", 20'h00001, {19'h0, link_ready});
    check("overrun", 20'h00001, {19'h0, link_overrun});
  endtask
  // Second reset with load held high: driver and cascade outputs and the sticky flag come back cleared, ready back high
  task automatic t_rerun();
    ser_load = 1'b1;
    rst_n = 1'b0;
    wait_clk(3);
    rst_n = 1'b1;
    wait_clk(10);
    check("outputs", 20'h00000, driver_outputs);
    check("cascade", 20'h00000, {19'h0, ser_dout});
    check("overrun", 20'h00000, {19'h0, link_overrun});
    check("ready", 20'h00001, {19'h0, link_ready});
    ser_load = 1'b0;
    wait_clk(10);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    rst_n = 1'b0;
    ser_load = 1'b0;
    ser_blank = 1'b0;
    drain_hold = 1'b0;
    wait_clk(10);
    rst_n = 1'b1;
    wait_clk(3);
    t_reset();
    t_load();
    t_hold();
    t_blank();
    t_overrun();
    t_rerun();
    results();
  end
endmodule
`default_nettype wire
